/* File: pic_pkg.sv */
// Package for the prioritized interrupt controller: register map, field layout, sources and timing.
// Assumes an AXI4-Lite master with 32-bit data and a single 125 MHz clock.
package pic_pkg;

    localparam int NUM_SRC = 9;

    // Byte offsets of the register words.
    localparam logic [7:0] OFF_ENABLE_HIGH  = 8'h00;
    localparam logic [7:0] OFF_ENABLE_LOW   = 8'h04;
    localparam logic [7:0] OFF_REQUEST_HIGH = 8'h08;
    localparam logic [7:0] OFF_REQUEST_LOW  = 8'h0c;
    localparam logic [7:0] OFF_STATUS_WORD  = 8'h10;
    localparam logic [7:0] OFF_EDGE_SELECT  = 8'h14;
    localparam logic [7:0] OFF_CONTROL      = 8'h18;
    localparam logic [7:0] OFF_ACCEPT_INFO  = 8'h1c;

    // Source indices in priority order; index 0 ranks highest.
    localparam int SRC_EXT_A    = 0;
    localparam int SRC_EXT_B    = 1;
    localparam int SRC_TIMER_A  = 2;
    localparam int SRC_TIMER_B  = 3;
    localparam int SRC_CONV     = 4;
    localparam int SRC_WATCHDOG = 5;
    localparam int SRC_INTERVAL = 6;
    localparam int SRC_SERIAL   = 7;
    localparam int SRC_BREAK    = 8;

    // Request and enable bits of the high word hold sources 0..3 in bits 7..4; low word sources 4..7.
    localparam int HIGH_BASE_BIT = 4;
    localparam int LOW_BASE_BIT  = 4;

    // Status word fields.
    localparam int STATUS_BREAK_BIT  = 4;
    localparam int STATUS_MASTER_BIT = 2;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Edge select: two bits per pin, pin a in [1:0], pin b in [3:2].
    localparam logic [1:0] EDGE_OFF     = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h1;
    localparam logic [1:0] EDGE_RISING  = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;
    localparam logic [7:0] EDGE_RESET   = 8'h00;

    // Control word bits written by the core sequencer.
    localparam int CTL_INSTR_DONE = 0;
    localparam int CTL_RETURN     = 1;
    localparam int CTL_BREAK      = 2;
    localparam int CTL_IRQ_ON     = 3;
    localparam int CTL_IRQ_OFF    = 4;

    // Vector table base and break vector, in program address bytes.
    localparam logic [15:0] VECTOR_BASE   = 16'hffe0;
    localparam logic [15:0] BREAK_VECTOR  = 16'hffde;

    // Acceptance takes eight oscillator periods at the 4 MHz reference.
    localparam int ACCEPT_PERIODS  = 8;
    localparam int OSC_PERIOD_NS   = 250;
    localparam int CLK_PERIOD_NS   = 8;
    localparam int ACCEPT_CYCLES   = (ACCEPT_PERIODS * OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STACK_PUSHES    = 3;

    typedef enum logic [1:0] {
        PIC_RESP_OKAY   = 2'h0,
        PIC_RESP_SLVERR = 2'h2
    } pic_resp_t;

    typedef struct packed {
        logic [15:0] vector;
        logic [3:0]  source;
        logic        active;
    } pic_accept_t;

endpackage

/* File: pic_controller.sv */
// Prioritized interrupt controller with an AXI4-Lite register slave.
// Assumes peripheral event pulses and the core sequencer on ref_clk; external pins are asynchronous.
`timescale 1ns/1ps

module pic_controller #(
    parameter int ACCEPT_LEN = pic_pkg::ACCEPT_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    input  wire logic [1:0]  timer_match,
    input  wire logic        interval_overflow,
    input  wire logic        conversion_done,
    input  wire logic        watchdog_match,
    input  wire logic        serial_done,
    input  wire logic [15:0] return_pc,
    input  wire logic [7:0]  stack_ptr,
    output logic             accept_busy,
    output logic             stack_push,
    output logic [7:0]       stack_push_data,
    output logic [7:0]       stack_push_addr,
    output logic             pc_load,
    output logic [15:0]      pc_load_value,
    output logic [7:0]       processor_status_word
);

    typedef enum logic [2:0] {
        PIC_IDLE,
        PIC_PUSH,
        PIC_WAIT,
        PIC_LOAD,
        PIC_POP
    } pic_state_t;

    localparam int NS = pic_pkg::NUM_SRC;

    logic [NS-1:0] req;
    logic [NS-2:0] enable;
    logic [7:0]    edge_select_reg;
    logic [4:0]    ctl_pulse;
    logic          brk_pending;
    logic [1:0]    pin_a_sync;
    logic [1:0]    pin_b_sync;
    logic [1:0]    pin_prev;
    logic [1:0]    pin_edge;
    logic [NS-1:0] eligible;
    logic [3:0]    winner;
    logic          winner_valid;
    logic [3:0]    accept_src;
    logic [1:0]    push_cnt;
    logic [15:0]   wait_cnt;
    logic [7:0]    saved_stat;
    logic [15:0]   saved_pc;
    pic_state_t    state;
    logic          aw_held;
    logic          w_held;
    logic [7:0]    aw_addr;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          wr_fire;
    logic          clear_high;
    logic          clear_low;
    logic [NS-1:0] accept_clear;

    function automatic logic edge_hit(input logic [1:0] mode, input logic prev, input logic now);
        edge_hit = ((mode == pic_pkg::EDGE_RISING || mode == pic_pkg::EDGE_BOTH) && !prev && now) ||
                   ((mode == pic_pkg::EDGE_FALLING || mode == pic_pkg::EDGE_BOTH) && prev && !now);
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        merge = s[0] ? d[7:0] : old;
    endfunction

    function automatic logic [3:0] upper_rev(input logic [7:0] b);
        upper_rev = {b[4], b[5], b[6], b[7]};
    endfunction

    // Pins pass two flops before the edge detector sees them.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pin_a_sync <= 2'h0;
            pin_b_sync <= 2'h0;
            pin_prev   <= 2'h0;
        end else begin
            pin_a_sync <= {pin_a_sync[0], ext_irq_pin_a};
            pin_b_sync <= {pin_b_sync[0], ext_irq_pin_b};
            pin_prev   <= {pin_b_sync[1], pin_a_sync[1]};
        end
    end

    always_comb begin
        pin_edge[0] = edge_hit(edge_select_reg[1:0], pin_prev[0], pin_a_sync[1]);
        pin_edge[1] = edge_hit(edge_select_reg[3:2], pin_prev[1], pin_b_sync[1]);
    end

    // AXI write path: address and data taken in either order, response after both.
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= pic_pkg::PIC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr[7:2] <= pic_pkg::OFF_CONTROL[7:2] && aw_addr[1:0] == 2'h0)
                              ? pic_pkg::PIC_RESP_OKAY : pic_pkg::PIC_RESP_SLVERR;
            end else if (s_axi_bready && s_axi_bvalid) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Enables, edge select and core control strobes.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            enable          <= '0;
            edge_select_reg <= pic_pkg::EDGE_RESET;
            ctl_pulse       <= 5'h00;
        end else begin
            ctl_pulse <= 5'h00;
            if (wr_fire) begin
                case (aw_addr)
                    pic_pkg::OFF_ENABLE_HIGH: begin
                        enable[3:0] <= upper_rev(merge({enable[0], enable[1], enable[2], enable[3], 4'h0},
                                                       w_data, w_strb));
                    end
                    pic_pkg::OFF_ENABLE_LOW: begin
                        enable[7:4] <= upper_rev(merge({enable[4], enable[5], enable[6], enable[7], 4'h0},
                                                       w_data, w_strb));
                    end
                    pic_pkg::OFF_EDGE_SELECT: begin
                        edge_select_reg <= merge(edge_select_reg, w_data, w_strb);
                    end
                    pic_pkg::OFF_CONTROL: begin
                        ctl_pulse <= w_strb[0] ? w_data[4:0] : 5'h00;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    assign clear_high = wr_fire && aw_addr == pic_pkg::OFF_REQUEST_HIGH && w_strb[0];
    assign clear_low  = wr_fire && aw_addr == pic_pkg::OFF_REQUEST_LOW && w_strb[0];

    // Request flags: hardware set wins over a software clear in the same cycle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            req <= '0;
        end else begin
            for (int i = 0; i < NS - 1; i++) begin
                if ((i < 4 && clear_high && !w_data[7 - i]) || (i >= 4 && clear_low && !w_data[11 - i])
                    || accept_clear[i]) begin
                    req[i] <= 1'b0;
                end
            end
            req[NS-1] <= 1'b0;
            if (pin_edge[0])        req[pic_pkg::SRC_EXT_A]    <= 1'b1;
            if (pin_edge[1])        req[pic_pkg::SRC_EXT_B]    <= 1'b1;
            if (timer_match[0])     req[pic_pkg::SRC_TIMER_A]  <= 1'b1;
            if (timer_match[1])     req[pic_pkg::SRC_TIMER_B]  <= 1'b1;
            if (conversion_done)    req[pic_pkg::SRC_CONV]     <= 1'b1;
            if (watchdog_match)     req[pic_pkg::SRC_WATCHDOG] <= 1'b1;
            if (interval_overflow)  req[pic_pkg::SRC_INTERVAL] <= 1'b1;
            if (serial_done)        req[pic_pkg::SRC_SERIAL]   <= 1'b1;
        end
    end

    // A break is taken after the first instruction at which no eligible request outranks it, regardless of enables.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            brk_pending <= 1'b0;
        end else if (ctl_pulse[pic_pkg::CTL_BREAK]) begin
            brk_pending <= 1'b1;
        end else if (state == PIC_IDLE && ctl_pulse[pic_pkg::CTL_INSTR_DONE] && winner == 4'(pic_pkg::SRC_BREAK)) begin
            brk_pending <= 1'b0;
        end
    end

    // Eligibility and fixed-priority pick; the lowest index wins.
    always_comb begin
        for (int i = 0; i < NS - 1; i++) begin
            eligible[i] = req[i] && enable[i] && processor_status_word[pic_pkg::STATUS_MASTER_BIT];
        end
        eligible[NS-1] = brk_pending;
        winner       = 4'h0;
        winner_valid = 1'b0;
        for (int i = NS - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                winner       = 4'(i);
                winner_valid = 1'b1;
            end
        end
    end

    always_comb begin
        accept_clear = '0;
        if (state == PIC_IDLE && winner_valid && ctl_pulse[pic_pkg::CTL_INSTR_DONE]) begin
            accept_clear[winner] = 1'b1;
        end
    end

    // Acceptance sequencer.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state                 <= PIC_IDLE;
            processor_status_word <= pic_pkg::STATUS_RESET;
            accept_src            <= 4'h0;
            push_cnt              <= 2'h0;
            wait_cnt              <= 16'h0000;
            saved_stat            <= 8'h00;
            saved_pc              <= 16'h0000;
            accept_busy           <= 1'b0;
            stack_push            <= 1'b0;
            stack_push_data       <= 8'h00;
            stack_push_addr       <= 8'h00;
            pc_load               <= 1'b0;
            pc_load_value         <= 16'h0000;
        end else begin
            stack_push <= 1'b0;
            pc_load    <= 1'b0;
            case (state)
                PIC_IDLE: begin
                    if (ctl_pulse[pic_pkg::CTL_IRQ_ON]) begin
                        processor_status_word[pic_pkg::STATUS_MASTER_BIT] <= 1'b1;
                    end else if (ctl_pulse[pic_pkg::CTL_IRQ_OFF]) begin
                        processor_status_word[pic_pkg::STATUS_MASTER_BIT] <= 1'b0;
                    end
                    if (ctl_pulse[pic_pkg::CTL_RETURN]) begin
                        state       <= PIC_POP;
                        accept_busy <= 1'b1;
                    end else if (winner_valid && ctl_pulse[pic_pkg::CTL_INSTR_DONE]) begin
                        state       <= PIC_PUSH;
                        accept_busy <= 1'b1;
                        accept_src  <= winner;
                        push_cnt    <= 2'h0;
                        wait_cnt    <= 16'h0000;
                        saved_pc    <= return_pc;
                        saved_stat  <= processor_status_word
                                     | ((winner == 4'(pic_pkg::SRC_BREAK)) ? 8'(1 << pic_pkg::STATUS_BREAK_BIT) : 8'h00);
                        processor_status_word[pic_pkg::STATUS_MASTER_BIT] <= 1'b0;
                        processor_status_word[pic_pkg::STATUS_BREAK_BIT]  <= winner == 4'(pic_pkg::SRC_BREAK);
                    end
                end
                PIC_PUSH: begin
                    wait_cnt        <= wait_cnt + 16'h0001;
                    stack_push      <= 1'b1;
                    stack_push_addr <= stack_ptr - 8'(push_cnt);
                    case (push_cnt)
                        2'h0:    stack_push_data <= saved_pc[15:8];
                        2'h1:    stack_push_data <= saved_pc[7:0];
                        default: stack_push_data <= saved_stat;
                    endcase
                    push_cnt <= push_cnt + 2'h1;
                    if (push_cnt == 2'(pic_pkg::STACK_PUSHES - 1)) begin
                        state <= PIC_WAIT;
                    end
                end
                PIC_WAIT: begin
                    wait_cnt <= wait_cnt + 16'h0001;
                    if (wait_cnt >= 16'(ACCEPT_LEN - 2)) begin
                        state <= PIC_LOAD;
                    end
                end
                PIC_LOAD: begin
                    pc_load       <= 1'b1;
                    pc_load_value <= (accept_src == 4'(pic_pkg::SRC_BREAK)) ? pic_pkg::BREAK_VECTOR
                                   : pic_pkg::VECTOR_BASE + {11'h000, accept_src, 1'b0};
                    accept_busy   <= 1'b0;
                    state         <= PIC_IDLE;
                end
                PIC_POP: begin
                    processor_status_word <= saved_stat;
                    pc_load               <= 1'b1;
                    pc_load_value         <= saved_pc;
                    accept_busy           <= 1'b0;
                    state                 <= PIC_IDLE;
                end
                default: begin
                    state <= PIC_IDLE;
                end
            endcase
        end
    end

    // AXI read path.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= pic_pkg::PIC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= pic_pkg::PIC_RESP_OKAY;
                case (s_axi_araddr)
                    pic_pkg::OFF_ENABLE_HIGH:  s_axi_rdata <= {24'h0, enable[0], enable[1], enable[2], enable[3], 4'h0};
                    pic_pkg::OFF_ENABLE_LOW:   s_axi_rdata <= {24'h0, enable[4], enable[5], enable[6], enable[7], 4'h0};
                    pic_pkg::OFF_REQUEST_HIGH: s_axi_rdata <= {24'h0, req[0], req[1], req[2], req[3], 4'h0};
                    pic_pkg::OFF_REQUEST_LOW:  s_axi_rdata <= {24'h0, req[4], req[5], req[6], req[7], 4'h0};
                    pic_pkg::OFF_STATUS_WORD:  s_axi_rdata <= {24'h0, processor_status_word};
                    pic_pkg::OFF_EDGE_SELECT:  s_axi_rdata <= {24'h0, edge_select_reg};
                    pic_pkg::OFF_CONTROL:      s_axi_rdata <= 32'h0000_0000;
                    pic_pkg::OFF_ACCEPT_INFO:  s_axi_rdata <= {27'h0, accept_src, accept_busy};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= pic_pkg::PIC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* File: pic_checker_properties.sv */
// Concurrent checks on the interrupt controller's core link and read answers.
// Assumes binding onto pic_controller with ref_clk and active-high asynchronous rst.
`timescale 1ns/1ps
module pic_checker #(
    parameter int ACCEPT_LEN = pic_pkg::ACCEPT_CYCLES
) (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        accept_busy,
    input wire logic        stack_push,
    input wire logic [7:0]  stack_push_addr,
    input wire logic        pc_load,
    input wire logic [7:0]  processor_status_word,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    localparam int BUSY_MAX = ACCEPT_LEN + 2;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_mask_clear; $rose(stack_push) |-> !processor_status_word[2]; endproperty
    property p_push_three; $rose(stack_push) |-> stack_push [*3] ##1 !stack_push; endproperty
    property p_push_addr;
        $rose(stack_push) |=> stack_push_addr == $past(stack_push_addr) - 8'h01
            ##1 stack_push_addr == $past(stack_push_addr, 2) - 8'h02;
    endproperty
    property p_accept_len; $rose(stack_push) |-> ##[3:ACCEPT_LEN] pc_load; endproperty
    property p_busy_push; stack_push |-> accept_busy; endproperty
    property p_pc_pulse; pc_load |=> !pc_load; endproperty
    property p_busy_bound; $rose(accept_busy) |-> ##[1:BUSY_MAX] !accept_busy; endproperty
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_mask_clear: assert property (p_mask_clear) else $error("master enable still set at push");
    a_push_three: assert property (p_push_three) else $error("push count wrong");
    a_push_addr: assert property (p_push_addr) else $error("push address not descending");
    a_accept_len: assert property (p_accept_len) else $error("vector load late");
    a_busy_push: assert property (p_busy_push) else $error("push outside acceptance");
    a_pc_pulse: assert property (p_pc_pulse) else $error("vector load not a pulse");
    a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    c_accept: cover property ($rose(stack_push));
    c_load: cover property (pc_load);
    c_rwait: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind pic_controller pic_checker #(.ACCEPT_LEN(ACCEPT_LEN)) pic_checker_i (.ref_clk(ref_clk), .rst(rst),
    .accept_busy(accept_busy), .stack_push(stack_push), .stack_push_addr(stack_push_addr), .pc_load(pc_load),
    .processor_status_word(processor_status_word), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata));

/* File: pic_core_model.sv */
// Behavioural core sequencer and stack facing the controller.
// Assumes one acceptance or return at a time; nesting beyond one level is not modelled.
`timescale 1ns/1ps
module pic_core_model (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        stack_push,
    input wire logic [7:0]  stack_push_data,
    input wire logic        pc_load,
    input wire logic [15:0] pc_load_value,
    output logic [15:0]     return_pc,
    output logic [7:0]      stack_ptr
);
    logic [7:0] pushed [0:2];
    logic [1:0] n_push;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            return_pc <= 16'h1234;
            stack_ptr <= 8'hff;
            n_push <= 2'h0;
        end else begin
            if (stack_push) begin
                pushed[n_push] <= stack_push_data;
                n_push <= n_push + 2'h1;
            end
            if (pc_load) begin
                // A load after three pushes is an acceptance; a load without pushes is a return.
                return_pc <= pc_load_value;
                n_push <= 2'h0;
                stack_ptr <= (n_push == 2'h3) ? stack_ptr - 8'h03 : stack_ptr + 8'h03;
            end
        end
    end
endmodule

/* File: tb_top.sv */
// Self-checking bench for the interrupt controller over its AXI4-Lite slave.
// Assumes the core model answers the stack and program counter side.
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, rst, awv, wv, bready, arv, rready, pin_a, pin_b, awready, wready, bvalid, arready, rvalid;
    logic busy, push, pc_load;
    logic [7:0] awaddr, araddr, spd, spa, stat, sp;
    logic [31:0] wdata, rdata, v;
    logic [5:0] ev;
    logic [1:0] bresp, rresp, r;
    logic [15:0] rpc, pcv;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    pic_controller #(.ACCEPT_LEN(6)) pic_controller_i (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_irq_pin_a(pin_a),
        .ext_irq_pin_b(pin_b), .timer_match(ev[5:4]), .interval_overflow(ev[3]), .conversion_done(ev[2]),
        .watchdog_match(ev[1]), .serial_done(ev[0]), .return_pc(rpc), .stack_ptr(sp), .accept_busy(busy),
        .stack_push(push), .stack_push_data(spd), .stack_push_addr(spa), .pc_load(pc_load),
        .pc_load_value(pcv), .processor_status_word(stat));
    pic_core_model pic_core_model_i (.ref_clk(ref_clk), .rst(rst), .stack_push(push), .stack_push_data(spd),
        .pc_load(pc_load), .pc_load_value(pcv), .return_pc(rpc), .stack_ptr(sp));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // The ceiling of 20000 cycles is dozens of times the length of the whole sequence.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            close_out();
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        awaddr <= a; wdata <= d; awv <= 1'b1; wv <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("write resp", 32'h0, {30'h0, bresp});
    endtask
    // Ready stands with the request, so the answer is taken at the edge where valid is first seen.
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        araddr <= a; arv <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arready) arv <= 1'b0;
        end while (!rvalid);
        v = rdata; r = rresp; rready <= 1'b0;
    endtask
    task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        rd(a); chk(nm, e, v);
    endtask
    task quiet();
        logic seen;
        seen = 1'b0;
        repeat (12) begin @(posedge ref_clk); seen = seen | busy; end
        chk("accept busy", 32'h0, {31'h0, seen});
    endtask
    task accept(input logic [15:0] vec);
        int i;
        i = 0;
        while (pc_load !== 1'b1 && i < 200) begin @(posedge ref_clk); i++; end
        chk("pc load value", {16'h0, vec}, {16'h0, pcv});
    endtask
    task pin(input logic a, input logic b);
        @(posedge ref_clk); pin_a <= a; pin_b <= b;
        repeat (6) @(posedge ref_clk);
    endtask
    initial begin
        {awv, wv, bready, arv, rready, pin_a, pin_b} = 7'h0;
        {awaddr, araddr, wdata, ev} = 54'h0;
        rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        rchk("status", 8'h10, 32'h0);
        rd(8'h40); chk("unmapped resp", 32'h2, {30'h0, r});
        wr(8'h00, 32'hf0); wr(8'h04, 32'hf0); wr(8'h18, 32'h08);
        rchk("status", 8'h10, 32'h04);
        @(posedge ref_clk); ev <= 6'h14; @(posedge ref_clk); ev <= 6'h0;
        rchk("req high", 8'h08, 32'h20); rchk("req low", 8'h0c, 32'h80);
        wr(8'h18, 32'h01); accept(16'hffe4);
        chk("pushes", 32'h123404, {8'h0, pic_core_model_i.pushed[0], pic_core_model_i.pushed[1],
            pic_core_model_i.pushed[2]});
        rchk("status", 8'h10, 32'h0); rchk("req high", 8'h08, 32'h0); rchk("req low", 8'h0c, 32'h80);
        wr(8'h18, 32'h01); quiet();
        wr(8'h18, 32'h02); accept(16'h1234); rchk("status", 8'h10, 32'h04);
        wr(8'h04, 32'h0); wr(8'h18, 32'h01); quiet();
        wr(8'h14, 32'h01); pin(1'b1, 1'b0); pin(1'b0, 1'b0); rchk("req high", 8'h08, 32'h80);
        wr(8'h18, 32'h01); accept(16'hffe0); rchk("req high", 8'h08, 32'h0);
        wr(8'h18, 32'h02); accept(16'h1234);
        wr(8'h14, 32'h0c); pin(1'b0, 1'b1); rchk("req high", 8'h08, 32'h40);
        wr(8'h08, 32'h0); rchk("req high", 8'h08, 32'h0);
        pin(1'b0, 1'b0); rchk("req high", 8'h08, 32'h40); wr(8'h08, 32'h0);
        wr(8'h14, 32'h08); pin(1'b0, 1'b1); wr(8'h08, 32'h0); pin(1'b0, 1'b0);
        rchk("req high", 8'h08, 32'h0);
        @(posedge ref_clk); ev <= 6'h2b; @(posedge ref_clk); ev <= 6'h0;
        rchk("req high", 8'h08, 32'h10); rchk("req low", 8'h0c, 32'hf0);
        wr(8'h04, 32'hf0); wr(8'h18, 32'h01); accept(16'hffe6);
        wr(8'h18, 32'h04); wr(8'h18, 32'h01); accept(16'hffde);
        rchk("status", 8'h10, 32'h10); rchk("accept info", 8'h1c, 32'h10);
        wr(8'h18, 32'h08); wr(8'h18, 32'h10); rchk("status", 8'h10, 32'h10);
        close_out();
    end
endmodule
